// file: fps_pkg.sv
// shared constants, types and helpers of the flyback protection supervisor
package fps_pkg;

   // clock
   localparam real CLK_MHZ = 200.0;

   // documented times, each in its own unit
   localparam real T_VCC_BLANK_US = 1.0;
   localparam real T_LEB_NS = 269.0;
   localparam real T_SEVERE_NS = 616.2;
   localparam real T_SEVERE_SS_US = 1.001;
   localparam real T_BROWN_OUT_MS = 1.09;
   localparam real T_BROWN_OUT_SS_MS = 5.27;
   localparam real T_SENSE_HIGH_MS = 10.0;
   localparam real T_FEEDBACK_HIGH_MS = 31.3;
   localparam real T_DIE_OTP_MS = 10.5;
   localparam real T_OVERLOAD_MS = 31.3;
   localparam real T_AUTO_RESTART_S = 3.0;
   localparam real T_SHORT_PULSE_US = 1.5;

   // cycle counts, least times rounded up
   localparam logic [31:0] VCC_BLANK_CYC = int'($ceil(T_VCC_BLANK_US * CLK_MHZ));
   localparam logic [31:0] LEB_CYC = int'($ceil(T_LEB_NS * CLK_MHZ / 1000.0));
   localparam logic [31:0] SEVERE_CYC = int'($ceil(T_SEVERE_NS * CLK_MHZ / 1000.0));
   localparam logic [31:0] SEVERE_SS_CYC = int'($ceil(T_SEVERE_SS_US * CLK_MHZ));
   localparam logic [31:0] BROWN_OUT_CYC = int'($ceil(T_BROWN_OUT_MS * CLK_MHZ * 1000.0));
   localparam logic [31:0] BROWN_OUT_SS_CYC =
      int'($ceil(T_BROWN_OUT_SS_MS * CLK_MHZ * 1000.0));
   localparam logic [31:0] SENSE_HIGH_CYC = int'($ceil(T_SENSE_HIGH_MS * CLK_MHZ * 1000.0));
   localparam logic [31:0] FEEDBACK_HIGH_CYC =
      int'($ceil(T_FEEDBACK_HIGH_MS * CLK_MHZ * 1000.0));
   localparam logic [31:0] DIE_OTP_CYC = int'($ceil(T_DIE_OTP_MS * CLK_MHZ * 1000.0));
   localparam logic [31:0] OVERLOAD_CYC = int'($ceil(T_OVERLOAD_MS * CLK_MHZ * 1000.0));
   localparam logic [31:0] AUTO_RESTART_CYC =
      int'($ceil(T_AUTO_RESTART_S * CLK_MHZ * 1000000.0));
   localparam logic [31:0] SHORT_PULSE_CYC = int'($ceil(T_SHORT_PULSE_US * CLK_MHZ));

   // peak current limit figures handed to the look-up logic
   localparam int PEAK_MAX_LOW_LINE_MV = 594;
   localparam logic [7:0] OVERLOAD_LIMIT_LOW_LINE = 8'hff;
   localparam logic [7:0] OVERLOAD_LIMIT_HIGH_LINE = 8'hca;

   // analog comparator results, each high when its condition holds
   typedef struct packed {
      logic vcc_above_on;          // 20.5 V
      logic vcc_above_off;         // 7.2 V
      logic vcc_above_raised_off;  // 9.6 V
      logic vcc_above_brown_in;    // 15 V
      logic hv_above_brown_in;     // 1.15 mA
      logic hv_below_brown_out;    // 0.443 mA
      logic cs_above_peak;         // peak current limit
      logic cs_above_severe;       // 0.8 V
      logic cs_above_sense_high;   // sense pin high trigger
      logic fb_above_high;         // 2.41 V
      logic die_above_otp;         // 130 degC
      logic die_below_release;     // 20 degC under the trip level
   } fps_cmp_type;

   // sticky record of what stopped the converter
   typedef struct packed {
      logic sense_short;
      logic overload;
      logic overvoltage;
      logic die_overtemp;
      logic feedback_high;
      logic sense_high;
      logic severe_overcurrent;
      logic brown_out;
   } fps_cause_type;

   typedef enum logic [2:0] {
      FPS_OFF        = 3'b000,
      FPS_WAIT_IN    = 3'b001,
      FPS_SOFT_START = 3'b010,
      FPS_RUN        = 3'b011,
      FPS_BROWN_OUT  = 3'b100,
      FPS_RESTART    = 3'b101,
      FPS_LATCH      = 3'b110
   } fps_state_type;

   // saturating dwell counter: runs while cond holds, clears otherwise
   function automatic logic [31:0] fps_dwell(input logic cond, input logic [31:0] cnt,
                                             input logic [31:0] lim);
      if (!cond) begin
         return 32'h0;
      end
      return (cnt >= lim) ? lim : cnt + 32'h1;
   endfunction

endpackage

// file: fps_sync_filter.sv
// three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/1ps
module fps_sync_filter #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous in, filtered out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire [WIDTH-1:0] next_dout = (agree & stage3) | (~agree & dout);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         dout <= next_dout;
      end
   end
endmodule

// file: fps_supervisor.sv
// fault supervision of a flyback pwm controller: lockout, brown-in/out and trips
`timescale 1ns/1ps

module fps_supervisor #(
   parameter logic [31:0] BROWN_OUT_CYC = fps_pkg::BROWN_OUT_CYC,
   parameter logic [31:0] BROWN_OUT_SS_CYC = fps_pkg::BROWN_OUT_SS_CYC,
   parameter logic [31:0] SENSE_HIGH_CYC = fps_pkg::SENSE_HIGH_CYC,
   parameter logic [31:0] FEEDBACK_HIGH_CYC = fps_pkg::FEEDBACK_HIGH_CYC,
   parameter logic [31:0] DIE_OTP_CYC = fps_pkg::DIE_OTP_CYC,
   parameter logic [31:0] OVERLOAD_CYC = fps_pkg::OVERLOAD_CYC,
   parameter logic [31:0] AUTO_RESTART_CYC = fps_pkg::AUTO_RESTART_CYC
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // comparator results, asynchronous
   input wire fps_pkg::fps_cmp_type CMP,
   // from the pwm engine on this clock
   input wire logic GATE_REQUEST,
   input wire logic SOFT_START_DONE,
   input wire logic BURST_SLEEP,
   input wire logic PEAK_LIMIT_HIT,
   input wire logic OV_SAMPLE_VALID,
   input wire logic OV_SAMPLE_HIGH,
   // static configuration
   input wire logic OVP_LATCH_SELECT,
   input wire logic OLP_ENABLE,
   input wire logic LOW_LINE,
   input wire logic [7:0] OVERVOLTAGE_COUNT_LIMIT,
   // gate and supply control
   output logic MAIN_GATE_DRIVE,
   output logic DEVICE_ACTIVE,
   output logic STARTUP_CELL_ON,
   output logic RAISED_OFF_SELECT,
   // status
   output logic SOFT_START_ACTIVE,
   output logic AUTO_RESTART_ACTIVE,
   output logic LATCH_OFF_ACTIVE,
   output logic [7:0] OVERLOAD_LIMIT_CODE,
   output fps_pkg::fps_cause_type FAULT_CAUSE
);
   import fps_pkg::*;

   fps_cmp_type cmp;
   fps_state_type state;
   fps_state_type next_state;

   logic [31:0] on_cnt;
   logic [31:0] off_cnt;
   logic [31:0] bo_cnt;
   logic [31:0] severe_cnt;
   logic [31:0] shigh_cnt;
   logic [31:0] fbh_cnt;
   logic [31:0] otp_cnt;
   logic [31:0] olp_cnt;
   logic [31:0] ar_cnt;
   logic [31:0] pulse_cnt;
   logic [8:0] ovp_cnt;
   logic [1:0] long_run;
   logic [1:0] examined;
   logic first_power;
   logic brown_out_seen;
   logic otp_hold;
   logic pulse_cut;

   fps_sync_filter #(
      .WIDTH($bits(fps_cmp_type))
   ) fps_sync_filter_inst (
      .clk(MCLK),
      .rst(RST),
      .din(CMP),
      .dout(cmp)
   );

   // operating phase
   wire in_ss = state == FPS_SOFT_START;
   wire switching = in_ss || state == FPS_RUN;
   wire evaluate = switching && !BURST_SLEEP;

   // supply lockout with spike blanking on both edges
   wire supply_low = brown_out_seen ? !cmp.vcc_above_raised_off : !cmp.vcc_above_off;
   wire [31:0] next_on_cnt = fps_dwell(cmp.vcc_above_on, on_cnt, VCC_BLANK_CYC);
   wire [31:0] next_off_cnt = fps_dwell(supply_low, off_cnt, VCC_BLANK_CYC);
   wire turn_on = on_cnt >= VCC_BLANK_CYC;
   wire turn_off = off_cnt >= VCC_BLANK_CYC;

   // brown-in is taken straight from the synchronised comparators
   wire brown_in = cmp.hv_above_brown_in && cmp.vcc_above_brown_in;

   // brown-out dwell, longer window while soft-starting
   wire [31:0] bo_lim = in_ss ? BROWN_OUT_SS_CYC : BROWN_OUT_CYC;
   wire [31:0] next_bo_cnt = fps_dwell(evaluate && cmp.hv_below_brown_out, bo_cnt, bo_lim);
   wire bo_trip = evaluate && bo_cnt >= bo_lim;

   // "longer than" windows trip one cycle past the figure
   wire [31:0] severe_lim = in_ss ? SEVERE_SS_CYC + 32'h1 : SEVERE_CYC + 32'h1;
   wire [31:0] next_severe_cnt =
      fps_dwell(evaluate && cmp.cs_above_severe, severe_cnt, severe_lim);
   wire severe_trip = evaluate && severe_cnt >= severe_lim;

   wire [31:0] next_shigh_cnt =
      fps_dwell(evaluate && cmp.cs_above_sense_high, shigh_cnt, SENSE_HIGH_CYC);
   wire shigh_trip = evaluate && shigh_cnt >= SENSE_HIGH_CYC;

   wire [31:0] next_fbh_cnt =
      fps_dwell(evaluate && cmp.fb_above_high, fbh_cnt, FEEDBACK_HIGH_CYC);
   wire fbh_trip = evaluate && fbh_cnt >= FEEDBACK_HIGH_CYC;

   wire [31:0] otp_lim = DIE_OTP_CYC + 32'h1;
   wire [31:0] next_otp_cnt = fps_dwell(evaluate && cmp.die_above_otp, otp_cnt, otp_lim);
   wire otp_trip = evaluate && otp_cnt >= otp_lim;

   // overload: symmetric timer, so short peaks in a long run do not trip
   wire olp_up = evaluate && PEAK_LIMIT_HIT;
   wire [31:0] olp_inc = (olp_cnt >= OVERLOAD_CYC) ? OVERLOAD_CYC : olp_cnt + 32'h1;
   wire [31:0] olp_dec = (olp_cnt == 32'h0) ? 32'h0 : olp_cnt - 32'h1;
   wire [31:0] next_olp_cnt = !switching ? 32'h0 : (olp_up ? olp_inc : olp_dec);
   wire olp_trip = evaluate && OLP_ENABLE && olp_cnt >= OVERLOAD_CYC;

   // output overvoltage filter, one step per sampled comparison
   wire ovp_step = evaluate && OV_SAMPLE_VALID;
   wire [8:0] ovp_inc = (ovp_cnt == 9'h1ff) ? ovp_cnt : ovp_cnt + 9'h1;
   wire [8:0] ovp_dec = (ovp_cnt == 9'h0) ? 9'h0 : ovp_cnt - 9'h1;
   wire [8:0] ovp_step_val = OV_SAMPLE_HIGH ? ovp_inc : ovp_dec;
   wire [8:0] next_ovp_cnt = !switching ? 9'h0 : (ovp_step ? ovp_step_val : ovp_cnt);
   wire [8:0] ovp_lim = {1'b0, OVERVOLTAGE_COUNT_LIMIT} + 9'h1;
   wire ovp_trip = evaluate && ovp_cnt >= ovp_lim;

   // gate pulse: leading-edge blanking, then peak limit ends the pulse
   wire past_leb = MAIN_GATE_DRIVE && pulse_cnt >= LEB_CYC;
   wire peak_now = past_leb && cmp.cs_above_peak;
   wire next_pulse_cut = GATE_REQUEST && (pulse_cut || peak_now);
   wire [31:0] next_pulse_cnt = MAIN_GATE_DRIVE ? pulse_cnt + 32'h1 : 32'h0;

   // sense pin short: first three pulses after power-up all too long
   wire pulse_end = !MAIN_GATE_DRIVE && pulse_cnt != 32'h0; // length still held, no loop via gate
   wire check_pulse = pulse_end && first_power && evaluate;
   wire pulse_long = pulse_cnt > SHORT_PULSE_CYC;
   wire short_trip = check_pulse && pulse_long && long_run == 2'h2;
   wire [1:0] next_long_run = !check_pulse ? long_run : (pulse_long ? long_run + 2'h1 : 2'h0);
   wire [1:0] next_examined = check_pulse ? examined + 2'h1 : examined;
   wire next_first_power = first_power && !(check_pulse && examined == 2'h2);

   // fault collection
   wire ovp_latch = ovp_trip && OVP_LATCH_SELECT;
   wire restart_fault = severe_trip || shigh_trip || fbh_trip || otp_trip || olp_trip
                        || short_trip || (ovp_trip && !OVP_LATCH_SELECT);
   wire any_fault = restart_fault || ovp_latch || bo_trip;
   wire [31:0] next_ar_cnt = (state == FPS_RESTART) ? fps_dwell(1'b1, ar_cnt, AUTO_RESTART_CYC)
                                                    : 32'h0;
   wire restart_done = ar_cnt >= AUTO_RESTART_CYC && !otp_hold;

   // a fresh soft-start wipes the cause record
   wire restarting = next_state == FPS_SOFT_START && state != FPS_SOFT_START;
   fps_cause_type new_cause;
   assign new_cause = '{
      sense_short: short_trip,
      overload: olp_trip,
      overvoltage: ovp_trip,
      die_overtemp: otp_trip,
      feedback_high: fbh_trip,
      sense_high: shigh_trip,
      severe_overcurrent: severe_trip,
      brown_out: bo_trip
   };
   wire fps_cause_type next_cause = restarting ? fps_cause_type'(8'h0)
                                               : (FAULT_CAUSE | new_cause);

   wire next_brown_out_seen = (brown_out_seen && !restarting)
                              || next_state == FPS_BROWN_OUT;
   wire next_otp_hold = otp_trip || (otp_hold && !cmp.die_below_release);

   // outputs, all registered
   wire next_gate = GATE_REQUEST && switching && !BURST_SLEEP && !any_fault
                    && next_state == state && !next_pulse_cut && !peak_now;
   wire next_active = next_state == FPS_WAIT_IN || next_state == FPS_SOFT_START
                      || next_state == FPS_RUN || next_state == FPS_BROWN_OUT;
   // stand-by states only recharge when the supply sags; regulation is outside
   wire standby = next_state == FPS_RESTART || next_state == FPS_LATCH;
   wire next_startup = next_state == FPS_OFF || (standby && !cmp.vcc_above_off);
   wire [7:0] next_limit_code = LOW_LINE ? OVERLOAD_LIMIT_LOW_LINE
                                         : OVERLOAD_LIMIT_HIGH_LINE;

   always_comb begin
      next_state = state;
      unique case (state)
         FPS_OFF: begin
            if (turn_on) begin
               next_state = FPS_WAIT_IN;
            end
         end
         FPS_WAIT_IN: begin
            if (turn_off) begin
               next_state = FPS_OFF;
            end else if (brown_in) begin
               next_state = FPS_SOFT_START;
            end
         end
         FPS_SOFT_START, FPS_RUN: begin
            if (turn_off) begin
               next_state = FPS_OFF;
            end else if (ovp_latch) begin
               next_state = FPS_LATCH;
            end else if (restart_fault) begin
               next_state = FPS_RESTART;
            end else if (bo_trip) begin
               next_state = FPS_BROWN_OUT;
            end else if (in_ss && SOFT_START_DONE) begin
               next_state = FPS_RUN;
            end
         end
         FPS_BROWN_OUT: begin
            if (turn_off) begin
               next_state = FPS_OFF;
            end
         end
         FPS_RESTART: begin
            if (restart_done) begin
               next_state = FPS_OFF;
            end
         end
         FPS_LATCH: begin
            next_state = FPS_LATCH;
         end
         default: begin
            next_state = FPS_OFF;
         end
      endcase
   end

   // timers
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         on_cnt <= 32'h0;
         off_cnt <= 32'h0;
         bo_cnt <= 32'h0;
         severe_cnt <= 32'h0;
         shigh_cnt <= 32'h0;
         fbh_cnt <= 32'h0;
         otp_cnt <= 32'h0;
         olp_cnt <= 32'h0;
         ar_cnt <= 32'h0;
         pulse_cnt <= 32'h0;
         ovp_cnt <= 9'h0;
      end else begin
         on_cnt <= next_on_cnt;
         off_cnt <= next_off_cnt;
         bo_cnt <= next_bo_cnt;
         severe_cnt <= next_severe_cnt;
         shigh_cnt <= next_shigh_cnt;
         fbh_cnt <= next_fbh_cnt;
         otp_cnt <= next_otp_cnt;
         olp_cnt <= next_olp_cnt;
         ar_cnt <= next_ar_cnt;
         pulse_cnt <= next_pulse_cnt;
         ovp_cnt <= next_ovp_cnt;
      end
   end

   // control state and flags
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state <= FPS_OFF;
         long_run <= 2'h0;
         examined <= 2'h0;
         first_power <= 1'b1;
         brown_out_seen <= 1'b0;
         otp_hold <= 1'b0;
         pulse_cut <= 1'b0;
      end else begin
         state <= next_state;
         long_run <= next_long_run;
         examined <= next_examined;
         first_power <= next_first_power;
         brown_out_seen <= next_brown_out_seen;
         otp_hold <= next_otp_hold;
         pulse_cut <= next_pulse_cut;
      end
   end

   // outputs
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         MAIN_GATE_DRIVE <= 1'b0;
         DEVICE_ACTIVE <= 1'b0;
         STARTUP_CELL_ON <= 1'b1;
         RAISED_OFF_SELECT <= 1'b0;
         SOFT_START_ACTIVE <= 1'b0;
         AUTO_RESTART_ACTIVE <= 1'b0;
         LATCH_OFF_ACTIVE <= 1'b0;
         OVERLOAD_LIMIT_CODE <= 8'h0;
         FAULT_CAUSE <= '0;
      end else begin
         MAIN_GATE_DRIVE <= next_gate;
         DEVICE_ACTIVE <= next_active;
         STARTUP_CELL_ON <= next_startup;
         RAISED_OFF_SELECT <= next_brown_out_seen;
         SOFT_START_ACTIVE <= next_state == FPS_SOFT_START;
         AUTO_RESTART_ACTIVE <= next_state == FPS_RESTART;
         LATCH_OFF_ACTIVE <= next_state == FPS_LATCH;
         OVERLOAD_LIMIT_CODE <= next_limit_code;
         FAULT_CAUSE <= next_cause;
      end
   end
endmodule

// file: fps_supervisor_checker.sv
// assertions on the ports of the protection supervisor
`timescale 1ns/1ps
module fps_supervisor_checker
   import fps_pkg::*;
#(
   parameter logic [31:0] AUTO_RESTART_CYC = fps_pkg::AUTO_RESTART_CYC
) (
   // clock, reset and inputs
   input wire logic MCLK,
   input wire logic RST,
   input wire logic GATE_REQUEST,
   input wire logic BURST_SLEEP,
   input wire logic LOW_LINE,
   // outputs
   input wire logic MAIN_GATE_DRIVE,
   input wire logic DEVICE_ACTIVE,
   input wire logic STARTUP_CELL_ON,
   input wire logic RAISED_OFF_SELECT,
   input wire logic SOFT_START_ACTIVE,
   input wire logic AUTO_RESTART_ACTIVE,
   input wire logic LATCH_OFF_ACTIVE,
   input wire logic [7:0] OVERLOAD_LIMIT_CODE,
   input wire fps_pkg::fps_cause_type FAULT_CAUSE
);
   logic [31:0] ar_cnt;

   // length of the current restart pause, judged when it ends
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ar_cnt <= 32'h0;
      end else begin
         ar_cnt <= AUTO_RESTART_ACTIVE ? ar_cnt + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   chk_gate_needs_request: assert property (
      $rose(MAIN_GATE_DRIVE) |-> $past(GATE_REQUEST) && !$past(BURST_SLEEP))
      else $error("gate rose without a request");
   chk_gate_fault_off: assert property (
      (AUTO_RESTART_ACTIVE || LATCH_OFF_ACTIVE) |-> !MAIN_GATE_DRIVE)
      else $error("gate driven in a protection state");
   chk_sleep_gate_off: assert property (BURST_SLEEP |=> !MAIN_GATE_DRIVE)
      else $error("gate driven in sleep");
   chk_gate_needs_run: assert property (
      MAIN_GATE_DRIVE |-> DEVICE_ACTIVE && !RAISED_OFF_SELECT)
      else $error("gate driven while blocked");
   chk_latch_holds: assert property (LATCH_OFF_ACTIVE |=> LATCH_OFF_ACTIVE)
      else $error("latch left without reset");
   chk_active_cell_off: assert property (
      DEVICE_ACTIVE |-> !STARTUP_CELL_ON && !AUTO_RESTART_ACTIVE && !LATCH_OFF_ACTIVE)
      else $error("active together with startup cell or protection");
   chk_restart_dwell: assert property (
      $fell(AUTO_RESTART_ACTIVE) |-> ar_cnt >= AUTO_RESTART_CYC - 32'h1)
      else $error("restart pause too short");
   chk_cause_stops: assert property (
      $rose(FAULT_CAUSE[7:1] != 7'h0) |-> ##[0:1] (AUTO_RESTART_ACTIVE || LATCH_OFF_ACTIVE))
      else $error("cause recorded without stop");
   chk_brown_out_raise: assert property (
      $rose(FAULT_CAUSE.brown_out) |-> ##[0:1] (RAISED_OFF_SELECT && DEVICE_ACTIVE))
      else $error("brown-out without raised threshold");
   chk_limit_code: assert property (1'h1 |=> OVERLOAD_LIMIT_CODE ==
      ($past(LOW_LINE) ? OVERLOAD_LIMIT_LOW_LINE : OVERLOAD_LIMIT_HIGH_LINE))
      else $error("wrong overload limit code");
   chk_soft_active: assert property (SOFT_START_ACTIVE |-> DEVICE_ACTIVE)
      else $error("soft-start while inactive");

   cover property ($rose(AUTO_RESTART_ACTIVE));
   cover property ($rose(LATCH_OFF_ACTIVE));
   cover property ($rose(RAISED_OFF_SELECT));
   cover property ($fell(MAIN_GATE_DRIVE) && GATE_REQUEST);
endmodule

bind fps_supervisor fps_supervisor_checker #(.AUTO_RESTART_CYC(AUTO_RESTART_CYC))
   fps_supervisor_checker_inst (.MCLK(MCLK), .RST(RST), .GATE_REQUEST(GATE_REQUEST),
   .BURST_SLEEP(BURST_SLEEP), .LOW_LINE(LOW_LINE), .MAIN_GATE_DRIVE(MAIN_GATE_DRIVE),
   .DEVICE_ACTIVE(DEVICE_ACTIVE), .STARTUP_CELL_ON(STARTUP_CELL_ON),
   .RAISED_OFF_SELECT(RAISED_OFF_SELECT), .SOFT_START_ACTIVE(SOFT_START_ACTIVE),
   .AUTO_RESTART_ACTIVE(AUTO_RESTART_ACTIVE), .LATCH_OFF_ACTIVE(LATCH_OFF_ACTIVE),
   .OVERLOAD_LIMIT_CODE(OVERLOAD_LIMIT_CODE), .FAULT_CAUSE(FAULT_CAUSE));

// file: fps_supervisor_tb.sv
// self-checking bench of the flyback protection supervisor
`timescale 1ns/1ps
module fps_supervisor_tb;
   import fps_pkg::*;
   // shortened timers keep the run brief
   localparam logic [31:0] BO_N = 32'h64;
   localparam logic [31:0] BO_SS_N = 32'hc8;
   localparam logic [31:0] SH_N = 32'h96;
   localparam logic [31:0] FB_N = 32'h96;
   localparam logic [31:0] OT_N = 32'h96;
   localparam logic [31:0] OL_N = 32'h96;
   localparam logic [31:0] AR_N = 32'h12c;
   logic mclk, rst, gate_request, soft_start_done, burst_sleep, peak_limit_hit;
   logic ov_valid, ov_high, ovp_latch, olp_en, low_line;
   logic [7:0] ov_limit;
   fps_cmp_type cmp;
   logic MAIN_GATE_DRIVE, DEVICE_ACTIVE, STARTUP_CELL_ON, RAISED_OFF_SELECT;
   logic SOFT_START_ACTIVE, AUTO_RESTART_ACTIVE, LATCH_OFF_ACTIVE;
   logic [7:0] OVERLOAD_LIMIT_CODE;
   fps_cause_type FAULT_CAUSE;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;

   fps_supervisor #(.BROWN_OUT_CYC(BO_N), .BROWN_OUT_SS_CYC(BO_SS_N), .SENSE_HIGH_CYC(SH_N),
      .FEEDBACK_HIGH_CYC(FB_N), .DIE_OTP_CYC(OT_N), .OVERLOAD_CYC(OL_N),
      .AUTO_RESTART_CYC(AR_N)) fps_supervisor_inst (.MCLK(mclk), .RST(rst), .CMP(cmp),
      .GATE_REQUEST(gate_request), .SOFT_START_DONE(soft_start_done),
      .BURST_SLEEP(burst_sleep), .PEAK_LIMIT_HIT(peak_limit_hit), .OV_SAMPLE_VALID(ov_valid),
      .OV_SAMPLE_HIGH(ov_high), .OVP_LATCH_SELECT(ovp_latch), .OLP_ENABLE(olp_en),
      .LOW_LINE(low_line), .OVERVOLTAGE_COUNT_LIMIT(ov_limit),
      .MAIN_GATE_DRIVE(MAIN_GATE_DRIVE), .DEVICE_ACTIVE(DEVICE_ACTIVE),
      .STARTUP_CELL_ON(STARTUP_CELL_ON), .RAISED_OFF_SELECT(RAISED_OFF_SELECT),
      .SOFT_START_ACTIVE(SOFT_START_ACTIVE), .AUTO_RESTART_ACTIVE(AUTO_RESTART_ACTIVE),
      .LATCH_OFF_ACTIVE(LATCH_OFF_ACTIVE), .OVERLOAD_LIMIT_CODE(OVERLOAD_LIMIT_CODE),
      .FAULT_CAUSE(FAULT_CAUSE));

   initial begin
      mclk = 1'h0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return AUTO_RESTART_ACTIVE | LATCH_OFF_ACTIVE;
         1: return RAISED_OFF_SELECT;
         2: return ~DEVICE_ACTIVE;
         3: return SOFT_START_ACTIVE;
         4: return DEVICE_ACTIVE;
         default: return ~AUTO_RESTART_ACTIVE;
      endcase
   endfunction

   // bounded wait; the cycle count must fall inside the window
   task automatic wait_n(input int sel, input int lo, input int hi);
      int n;
      n = 0;
      while (sig(sel) !== 1'h1 && n <= hi) begin
         @(negedge mclk);
         n++;
      end
      check(n >= lo && n <= hi, 1'h1);
   endtask

   task automatic power_up(input logic hv, input logic lat);
      @(posedge mclk);
      rst <= 1'h1;
      cmp <= 12'h0;
      {gate_request, soft_start_done, burst_sleep, peak_limit_hit, ov_valid} <= 5'h0;
      ovp_latch <= lat;
      repeat (6) @(posedge mclk);
      check({STARTUP_CELL_ON, DEVICE_ACTIVE, MAIN_GATE_DRIVE}, 3'h4);
      rst <= 1'h0;
      cmp <= {4'hf, hv, 6'h00, 1'h1};
      wait_n(4, 200, 215);
      check(OVERLOAD_LIMIT_CODE, low_line ? 8'hff : 8'hca);
      if (hv) begin
         wait_n(3, 0, 3);
      end
   endtask

   task automatic ov_pulse(input logic v);
      @(posedge mclk);
      ov_valid <= 1'h1;
      ov_high <= v;
      @(posedge mclk);
      ov_valid <= 1'h0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic brown_in_case();
      power_up(1'h0, 1'h0);
      @(posedge mclk);
      gate_request <= 1'h1;
      repeat (20) @(negedge mclk);
      check({SOFT_START_ACTIVE, MAIN_GATE_DRIVE, DEVICE_ACTIVE}, 3'h1);
      @(posedge mclk);
      cmp.hv_above_brown_in <= 1'h1;
      wait_n(3, 0, 8);
      @(posedge mclk);
      gate_request <= 1'h0;
      cmp.vcc_above_off <= 1'h0;
      wait_n(2, 200, 215);
      check(STARTUP_CELL_ON, 1'h1);
   endtask

   task automatic gate_case();
      power_up(1'h1, 1'h0);
      @(posedge mclk);
      gate_request <= 1'h1;
      cmp.cs_above_peak <= 1'h1;
      @(posedge mclk);
      @(negedge mclk);
      check(MAIN_GATE_DRIVE, 1'h1);
      repeat (45) @(negedge mclk);
      check(MAIN_GATE_DRIVE, 1'h1);
      repeat (20) @(negedge mclk);
      check(MAIN_GATE_DRIVE, 1'h0);
      @(posedge mclk);
      gate_request <= 1'h0;
      soft_start_done <= 1'h1;
      repeat (4) @(negedge mclk);
      check({SOFT_START_ACTIVE, DEVICE_ACTIVE}, 2'h1);
   endtask

   task automatic severe_case();
      for (int i = 0; i < 2; i++) begin
         power_up(1'h1, 1'h0);
         @(posedge mclk);
         soft_start_done <= i[0];
         repeat (3) @(posedge mclk);
         cmp.cs_above_severe <= 1'h1;
         wait_n(0, i ? SEVERE_CYC : SEVERE_SS_CYC, (i ? SEVERE_CYC : SEVERE_SS_CYC) + 15);
         check(FAULT_CAUSE, 8'h02);
      end
   endtask

   task automatic sense_case();
      power_up(1'h1, 1'h0);
      @(posedge mclk);
      burst_sleep <= 1'h1;
      cmp.cs_above_sense_high <= 1'h1;
      repeat (SH_N + 40) @(negedge mclk);
      check(AUTO_RESTART_ACTIVE, 1'h0);
      @(posedge mclk);
      burst_sleep <= 1'h0;
      wait_n(0, SH_N, SH_N + 15);
      check(FAULT_CAUSE, 8'h04);
      @(posedge mclk);
      cmp.cs_above_sense_high <= 1'h0;
      wait_n(5, AR_N - 2, AR_N + 5);
      check(STARTUP_CELL_ON, 1'h1);
      wait_n(3, 0, 220);
      check(FAULT_CAUSE, 8'h00);
   endtask

   task automatic fb_case();
      power_up(1'h1, 1'h0);
      @(posedge mclk);
      cmp.fb_above_high <= 1'h1;
      wait_n(0, FB_N, FB_N + 15);
      check(FAULT_CAUSE, 8'h08);
   endtask

   task automatic otp_case();
      power_up(1'h1, 1'h0);
      @(posedge mclk);
      cmp.die_above_otp <= 1'h1;
      cmp.die_below_release <= 1'h0;
      wait_n(0, OT_N, OT_N + 15);
      check(FAULT_CAUSE, 8'h10);
      @(posedge mclk);
      cmp.die_above_otp <= 1'h0;
      repeat (AR_N + 40) @(negedge mclk);
      check(AUTO_RESTART_ACTIVE, 1'h1);
      @(posedge mclk);
      cmp.die_below_release <= 1'h1;
      wait_n(5, 0, 8);
   endtask

   // count walks 0 0 1 2 3 2 3, then one more high reaches limit plus one
   task automatic ovp_case(input logic lat);
      logic [6:0] pat;
      pat = 7'h1d;
      power_up(1'h1, lat);
      for (int i = 6; i >= 0; i--) begin
         ov_pulse(pat[i]);
      end
      @(negedge mclk);
      check({AUTO_RESTART_ACTIVE, LATCH_OFF_ACTIVE}, 2'h0);
      ov_pulse(1'h1);
      @(negedge mclk);
      check({AUTO_RESTART_ACTIVE, LATCH_OFF_ACTIVE}, lat ? 2'h1 : 2'h2);
      check(FAULT_CAUSE, 8'h20);
      repeat (AR_N + 40) @(negedge mclk);
      check(LATCH_OFF_ACTIVE, lat);
   endtask

   task automatic brown_case();
      for (int i = 0; i < 2; i++) begin
         power_up(1'h1, 1'h0);
         @(posedge mclk);
         soft_start_done <= i[0];
         repeat (3) @(posedge mclk);
         cmp.hv_below_brown_out <= 1'h1;
         wait_n(1, i ? BO_N : BO_SS_N, (i ? BO_N : BO_SS_N) + 15);
         check({DEVICE_ACTIVE, MAIN_GATE_DRIVE, FAULT_CAUSE}, 10'h201);
         @(posedge mclk);
         cmp.vcc_above_raised_off <= 1'h0;
         wait_n(2, 200, 215);
         check(STARTUP_CELL_ON, 1'h1);
      end
   endtask

   task automatic short_case();
      power_up(1'h1, 1'h0);
      repeat (3) begin
         @(posedge mclk);
         gate_request <= 1'h1;
         repeat (SHORT_PULSE_CYC + 20) @(posedge mclk);
         gate_request <= 1'h0;
         repeat (20) @(posedge mclk);
      end
      @(negedge mclk);
      check({AUTO_RESTART_ACTIVE, FAULT_CAUSE}, 9'h180);
   endtask

   // 100 up and 50 down leave 100 more to reach the limit
   task automatic olp_case();
      @(posedge mclk);
      low_line <= 1'h0;
      power_up(1'h1, 1'h0);
      @(posedge mclk);
      peak_limit_hit <= 1'h1;
      repeat (100) @(posedge mclk);
      peak_limit_hit <= 1'h0;
      repeat (50) @(posedge mclk);
      peak_limit_hit <= 1'h1;
      wait_n(0, OL_N - 55, OL_N - 35);
      check(FAULT_CAUSE, 8'h40);
   endtask

   initial begin
      rst = 1'h1;
      cmp = 12'h0;
      {gate_request, soft_start_done, burst_sleep, peak_limit_hit} = 4'h0;
      {ov_valid, ov_high, ovp_latch} = 3'h0;
      olp_en = 1'h1;
      low_line = 1'h1;
      ov_limit = 8'h03;
      brown_in_case();
      gate_case();
      severe_case();
      sense_case();
      fb_case();
      otp_case();
      ovp_case(1'h0);
      ovp_case(1'h1);
      brown_case();
      short_case();
      olp_case();
      print_verdict();
   end
endmodule
